// ---- hdl/mea_pkg.sv ----
package mea_pkg;

  // Medium selection codes
  localparam logic [1:0] MEA_PHY_TP_STD = 2'h0;
  localparam logic [1:0] MEA_PHY_THIN = 2'h1;
  localparam logic [1:0] MEA_PHY_THICK = 2'h2;
  localparam logic [1:0] MEA_PHY_TP_LOW = 2'h3;

  // Clock and timing
  localparam int MEA_CLK_MHZ = 10;
  localparam logic [3:0] MEA_LOCK_BITS = 4'h6;
  localparam logic [3:0] MEA_OSC_LOST_CYCLES = 4'h8;
  localparam logic [2:0] MEA_COL_QUAL_CYCLES = 3'h2;

  // Transmit buffer shape
  localparam int MEA_FIFO_WIDTH = 1;
  localparam int MEA_FIFO_DEPTH = 16;

  // Reset values of the line outputs
  localparam logic MEA_LINE_IDLE = 1'b0;
  localparam logic MEA_LED_OFF_OEN = 1'b1;

  typedef enum logic [2:0] {
    MEA_TX_IDLE = 3'b001,
    MEA_TX_SEND = 3'b010,
    MEA_TX_ABORT = 3'b100
  } mea_tx_state_type;

  typedef enum logic [1:0] {
    MEA_RX_HUNT = 2'b01,
    MEA_RX_LOCK = 2'b10
  } mea_rx_state_type;

endpackage : mea_pkg

// ---- hdl/mea_endec.sv ----
// Overview of operation
// R1: Oscillator rate halved to form the transmit clock for the controller.
// R2: Oscillator must run; without it no transmission or reception starts.
// R3: Controller NRZ bits are Manchester coded and driven on the differential pair.
// R4: Received Manchester is turned back into NRZ data with clock pulses.
// R5: Recovered data is flagged valid after six bit times of lock.
// R6: Decoder tolerates edge jitter up to twenty nanoseconds by realigning cells.
// R7: Both transmit outputs sit at the same level while idle.
// R8: In thin and thick coax modes, a qualified collision signal on the collision pair is reported to the controller.
// R9: On collision the device abandons the current frame so a retry can follow.
// R10: Collision LED lights only for collisions during network activity, not heartbeat.
// R11: Each cell has a mid transition, rising for one, falling for zero.
// R12: Two-bit medium select picks twisted pair, thin coax or thick coax.
// R13: Thick/thin output is low for thick coax and high for thin coax.
`timescale 1ns/1ps

module mea_fifo
  import mea_pkg::*;
#(
  parameter int WIDTH = MEA_FIFO_WIDTH,
  parameter int DEPTH = MEA_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Filling side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Draining side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  // Pointers wrap by overflow, so DEPTH must be a power of two
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic inReady_q;
  wire push = inValid && inReady_q;
  wire pop = outValid && outReady;

  // Occupancy decode; ready is registered from the next count so it never lags a fill
  assign count_d = count_q + (AW + 1)'(push) - (AW + 1)'(pop);
  assign inReady = inReady_q;
  assign outValid = (count_q != '0);
  assign outData = mem_q[rdPtr_q];

  // Pointer and count update
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      inReady_q <= 1'b0;
    end else begin
      wrPtr_q <= wrPtr_q + AW'(push);
      rdPtr_q <= rdPtr_q + AW'(pop);
      count_q <= count_d;
      inReady_q <= (count_d != FULL_COUNT);
    end
  end

  // Storage, one flip-flop word per entry
  for (genvar i = 0; i < DEPTH; i++) begin : gEntry
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        mem_q[i] <= '0;
      end else if (push && (wrPtr_q == AW'(i))) begin
        mem_q[i] <= inData;
      end
    end
  end

endmodule : mea_fifo

module mea_endec
  import mea_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Oscillator
  input wire logic oscIn,
  output logic oscOut,
  output logic txClk,
  // Configuration
  input wire logic [1:0] mediumSelect,
  output logic thickThin,
  // Controller transmit side
  input wire logic txEn,
  input wire logic txValid,
  input wire logic txData,
  output logic txReady,
  output logic txAbort,
  // Differential transmit pair
  output logic auiTxPos,
  output logic auiTxNeg,
  // Receive pair after the squelch comparator
  input wire logic auiRxIn,
  input wire logic auiRxSquelch,
  // Controller receive side
  output logic rxData,
  output logic rxClkPulse,
  output logic rxCarrier,
  // Collision pair and indicator
  input wire logic collisionPairIn,
  output logic colDetect,
  output logic colLedOut,
  output logic colLedOeN
);

  mea_tx_state_type txState_q;
  mea_tx_state_type txState_d;
  mea_rx_state_type rxState_q;
  logic txClk_q;
  logic oscOut_q;
  logic oscPrev_q;
  logic [3:0] oscIdle_q;
  logic thickThin_q;
  logic txHalf_q;
  logic txBit_q;
  logic txPos_q;
  logic txNeg_q;
  logic txAbort_q;
  logic rxPrev_q;
  logic rxHalf_q;
  logic [3:0] rxBits_q;
  logic rxData_q;
  logic rxClk_q;
  logic rxCarrier_q;
  logic [2:0] colCnt_q;
  logic colDetect_q;
  logic ledOn_q;
  logic fifoValid;
  logic fifoData;
  logic fifoReady;

  // Transmit bits wait here so the encoder can stall the controller
  mea_fifo #(
    .WIDTH(MEA_FIFO_WIDTH),
    .DEPTH(MEA_FIFO_DEPTH)
  ) uTxFifo (
    .clk(clk),
    .rst(rst),
    .inValid(txValid),
    .inData(txData),
    .inReady(txReady),
    .outValid(fifoValid),
    .outData(fifoData),
    .outReady(fifoReady)
  );

  // Mode and condition decode
  wire auiMode = (mediumSelect == MEA_PHY_THIN) || (mediumSelect == MEA_PHY_THICK); // R12
  wire oscRun = (oscIdle_q != MEA_OSC_LOST_CYCLES); // R2
  wire colValid = auiMode && (colCnt_q == MEA_COL_QUAL_CYCLES) && collisionPairIn; // R8
  wire netActive = txEn || auiRxSquelch;
  wire cellStart = (txState_q == MEA_TX_IDLE) || ((txState_q == MEA_TX_SEND) && !txHalf_q);
  wire startBit = cellStart && fifoValid && oscRun && !colValid;
  wire dropBit = (txState_q == MEA_TX_ABORT) && fifoValid;
  assign fifoReady = startBit || dropBit;

  // Oscillator divider and presence watch; a stalled oscillator blocks new bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txClk_q <= 1'b0;
      oscOut_q <= 1'b0;
      oscPrev_q <= 1'b0;
      oscIdle_q <= MEA_OSC_LOST_CYCLES;
    end else begin
      txClk_q <= !txClk_q; // R1
      oscOut_q <= !oscIn;
      oscPrev_q <= oscIn;
      if (oscIn != oscPrev_q) begin
        oscIdle_q <= 4'h0; // R2
      end else if (oscRun) begin
        oscIdle_q <= oscIdle_q + 4'h1;
      end
    end
  end

  // Thick/thin select; twisted pair modes leave it high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      thickThin_q <= 1'b1;
    end else begin
      thickThin_q <= (mediumSelect != MEA_PHY_THICK); // R13
    end
  end

  // Encoder sequencing
  always_comb begin
    txState_d = txState_q;
    case (txState_q)
      MEA_TX_IDLE: begin
        if (startBit) begin
          txState_d = MEA_TX_SEND;
        end
      end
      MEA_TX_SEND: begin
        if (colValid) begin
          txState_d = MEA_TX_ABORT; // R9
        end else if (!txHalf_q && !fifoValid) begin
          txState_d = MEA_TX_IDLE;
        end
      end
      MEA_TX_ABORT: begin
        // Hold until the controller drops its frame and the buffer is flushed
        if (!txEn && !fifoValid) begin
          txState_d = MEA_TX_IDLE; // R9
        end
      end
      default: begin
        txState_d = MEA_TX_IDLE;
      end
    endcase
  end

  // Encoder line drive, one clock per half cell
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txState_q <= MEA_TX_IDLE;
      txHalf_q <= 1'b0;
      txBit_q <= 1'b0;
      txPos_q <= MEA_LINE_IDLE;
      txNeg_q <= MEA_LINE_IDLE;
      txAbort_q <= 1'b0;
    end else begin
      txState_q <= txState_d;
      txAbort_q <= (txState_d == MEA_TX_ABORT); // R9
      if (startBit) begin
        txBit_q <= fifoData; // R3
        txHalf_q <= 1'b1;
        txPos_q <= !fifoData; // R11
        txNeg_q <= fifoData;
      end else if ((txState_q == MEA_TX_SEND) && txHalf_q && !colValid) begin
        txHalf_q <= 1'b0;
        txPos_q <= txBit_q; // R11
        txNeg_q <= !txBit_q;
      end else begin
        txHalf_q <= 1'b0;
        txPos_q <= MEA_LINE_IDLE; // R7
        txNeg_q <= MEA_LINE_IDLE; // R7
      end
    end
  end

  // Decoder: two equal samples mark a cell boundary, a missing mid edge realigns
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxState_q <= MEA_RX_HUNT;
      rxPrev_q <= 1'b0;
      rxHalf_q <= 1'b0;
      rxBits_q <= 4'h0;
      rxData_q <= 1'b0;
      rxClk_q <= 1'b0;
      rxCarrier_q <= 1'b0;
    end else begin
      rxPrev_q <= auiRxIn;
      rxClk_q <= 1'b0;
      if (!auiRxSquelch || !oscRun) begin
        rxState_q <= MEA_RX_HUNT; // R2
        rxHalf_q <= 1'b0;
        rxBits_q <= 4'h0;
        rxCarrier_q <= 1'b0;
      end else if (rxState_q != MEA_RX_LOCK) begin
        if (auiRxIn == rxPrev_q) begin
          rxState_q <= MEA_RX_LOCK;
          rxHalf_q <= 1'b1;
        end
      end else if (rxHalf_q && (auiRxIn == rxPrev_q)) begin
        // Late or early edge: this sample opens a new cell
        rxHalf_q <= 1'b1; // R6
      end else if (rxHalf_q) begin
        rxHalf_q <= 1'b0;
        if (rxBits_q != MEA_LOCK_BITS) begin
          rxBits_q <= rxBits_q + 4'h1; // R5
        end else begin
          rxCarrier_q <= 1'b1; // R5
          rxData_q <= auiRxIn; // R4
          rxClk_q <= 1'b1; // R4
        end
      end else begin
        rxHalf_q <= 1'b1;
      end
    end
  end

  // Collision qualification and indicator; heartbeat comes with no activity
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      colCnt_q <= 3'h0;
      colDetect_q <= 1'b0;
      ledOn_q <= 1'b0;
    end else begin
      if (!collisionPairIn) begin
        colCnt_q <= 3'h0;
      end else if (colCnt_q != MEA_COL_QUAL_CYCLES) begin
        colCnt_q <= colCnt_q + 3'h1; // R8
      end
      colDetect_q <= colValid; // R8
      ledOn_q <= colValid && netActive; // R10
    end
  end

  // Output wiring, all from flip-flops except colLedOut, which is tied low
  assign oscOut = oscOut_q;
  assign txClk = txClk_q;
  assign thickThin = thickThin_q;
  assign txAbort = txAbort_q;
  assign auiTxPos = txPos_q;
  assign auiTxNeg = txNeg_q;
  assign rxData = rxData_q;
  assign rxClkPulse = rxClk_q;
  assign rxCarrier = rxCarrier_q;
  assign colDetect = colDetect_q;
  assign colLedOut = 1'b0;
  assign colLedOeN = !ledOn_q; // Open drain: enable low pulls the LED on

endmodule : mea_endec

// ---- testbench/mea_checker.sv ----
`timescale 1ns/1ps
module mea_checker
  import mea_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire logic txClk,
  input wire logic [1:0] mediumSelect,
  input wire logic thickThin,
  input wire logic txEn,
  input wire logic txAbort,
  input wire logic auiTxPos,
  input wire logic auiTxNeg,
  input wire logic auiRxSquelch,
  input wire logic rxClkPulse,
  input wire logic rxCarrier,
  input wire logic collisionPairIn,
  input wire logic colDetect,
  input wire logic colLedOut,
  input wire logic colLedOeN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Line and clock outputs
  // First edge after release is skipped, since its past value is the reset level
  txclk_div_a: assert property (!$past(rst) |-> txClk != $past(txClk))
    else $error("txClk stalled");
  line_idle_a: assert property (!(auiTxPos && auiTxNeg)) else $error("both high");
  cell_pair_a: assert property ($past(auiTxPos == auiTxNeg) && auiTxPos != auiTxNeg |=>
    txAbort || (auiTxPos == $past(auiTxNeg) && auiTxNeg == $past(auiTxPos)))
    else $error("cell halves not inverted");
  medium_out_a: assert property (thickThin == ($past(mediumSelect) != MEA_PHY_THICK))
    else $error("thickThin wrong");
  // Collision path; pair ignored in twisted pair modes
  col_qual_a: assert property ((collisionPairIn && mediumSelect[0] != mediumSelect[1])[*3]
    |-> ##[0:1] colDetect) else $error("collision missed");
  col_tp_a: assert property ((mediumSelect[0] == mediumSelect[1])[*4] |-> !colDetect)
    else $error("collision in TP mode");
  abort_quiet_a: assert property (txAbort |-> !auiTxPos && !auiTxNeg)
    else $error("line active in abort");
  col_abort_a: assert property ($rose(colDetect) && $past(auiTxPos != auiTxNeg)
    |-> ##[0:1] txAbort) else $error("no abort");
  led_cause_a: assert property (!colLedOeN |-> $past(txEn || auiRxSquelch) &&
    (colDetect || $past(colDetect))) else $error("LED without cause");
  led_pin_a: assert property (colLedOut == 1'b0) else $error("LED pin high");
  // Receive outputs
  rx_pulse_a: assert property (rxClkPulse |=> !rxClkPulse) else $error("long pulse");
  rx_drop_a: assert property (!auiRxSquelch |-> ##[1:2] !rxCarrier)
    else $error("carrier held");
endmodule : mea_checker

// ---- testbench/tb_xcvr.sv ----
`timescale 1ns/1ps
module tb_xcvr (
  // Clock
  input wire logic clk,
  // Pairs toward the device
  output logic rxIn,
  output logic squelch,
  output logic colPair
);
  logic drv = 1'b0;
  logic noise = 1'b0;
  initial squelch = 1'b0;
  initial colPair = 1'b0;
  // Released pair toggles so a stale level never passes for data
  always @(negedge clk) noise <= ~noise;
  assign rxIn = squelch ? drv : noise;
  // Each cell: inverse bit then bit; cell late has a late mid edge (jitter)
  task sendBits(input logic [23:0] v, input int late);
    squelch = 1'b1;
    for (int i = 0; i < 24; i++) begin
      drv = ~v[i];
      @(negedge clk);
      if (i == late) @(negedge clk);
      drv = v[i];
      @(negedge clk);
    end
    squelch = 1'b0;
  endtask : sendBits
  // Squelched collision signal held for n cycles
  task colBurst(input int n);
    colPair = 1'b1;
    repeat (n) @(negedge clk);
    colPair = 1'b0;
  endtask : colBurst
endmodule : tb_xcvr

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import mea_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic oscIn = 1'b0;
  logic oscStop = 1'b0;
  logic [1:0] mediumSelect = MEA_PHY_THIN;
  logic txEn = 1'b0;
  logic txValid = 1'b0;
  logic txData = 1'b0;
  wire logic oscOut, txClk, thickThin, txReady, txAbort, auiTxPos, auiTxNeg;
  wire logic auiRxIn, auiRxSquelch, rxData, rxClkPulse, rxCarrier;
  wire logic collisionPairIn, colDetect, colLedOut, colLedOeN;
  int bad_count = 0;
  int n_checks = 0;
  int k;
  // Clock and oscillator pin; the oscillator may be stopped
  always #50 clk = ~clk;
  always @(negedge clk) if (!oscStop) oscIn <= ~oscIn;
  mea_endec i_dut (.clk(clk), .rst(rst), .oscIn(oscIn), .oscOut(oscOut), .txClk(txClk),
    .mediumSelect(mediumSelect), .thickThin(thickThin), .txEn(txEn), .txValid(txValid),
    .txData(txData), .txReady(txReady), .txAbort(txAbort), .auiTxPos(auiTxPos),
    .auiTxNeg(auiTxNeg), .auiRxIn(auiRxIn), .auiRxSquelch(auiRxSquelch), .rxData(rxData),
    .rxClkPulse(rxClkPulse), .rxCarrier(rxCarrier), .collisionPairIn(collisionPairIn),
    .colDetect(colDetect), .colLedOut(colLedOut), .colLedOeN(colLedOeN));
  tb_xcvr i_xcvr (.clk(clk), .rxIn(auiRxIn), .squelch(auiRxSquelch),
    .colPair(collisionPairIn));
  task chk(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  // Offer one bit at a falling edge, hold it until taken
  task push(input logic d);
    txValid = 1'b1;
    txData = d;
    k = 0;
    while (txReady !== 1'b1 && k < 200) begin step(1); k++; end
    if (k >= 200) bad_count++;
    step(1);
  endtask : push
  task t_clk;
    logic p;
    p = txClk;
    step(1);
    chk({txClk, oscOut}, {~p, ~oscIn});
  endtask : t_clk
  task t_medium;
    for (int i = 0; i < 4; i++) begin
      mediumSelect = i[1:0];
      step(2);
      chk({1'b0, thickThin}, {1'b0, i != 2});
    end
  endtask : t_medium
  // Byte sent LSB first while the line is watched half cell by half cell
  task t_tx;
    logic [7:0] v;
    v = 8'hA5;
    txEn = 1'b1;
    fork
      begin for (int i = 0; i < 8; i++) push(v[i]); txValid = 1'b0; end
      begin
        for (int w = 0; w < 50 && auiTxPos === auiTxNeg; w++) step(1);
        for (int i = 0; i < 8; i++) begin
          chk({auiTxPos, auiTxNeg}, {~v[i], v[i]});
          step(1);
          chk({auiTxPos, auiTxNeg}, {v[i], ~v[i]});
          step(1);
        end
        chk({auiTxPos, auiTxNeg}, 2'h0);
      end
    join
    txEn = 1'b0;
  endtask : t_tx
  // Stopped oscillator: buffer fills and refuses, then drains once it runs
  task t_fill;
    oscStop = 1'b1;
    step(10);
    for (int i = 0; i < 16; i++) push(i[0]);
    txValid = 1'b0;
    step(1);
    chk({txReady, auiTxPos | auiTxNeg}, 2'h0);
    oscStop = 1'b0;
    step(50);
    chk({txReady, auiTxPos | auiTxNeg}, 2'h2);
  endtask : t_fill
  task t_rx;
    logic p;
    int n;
    n = 0;
    fork
      i_xcvr.sendBits(24'h555555, 12);
      repeat (52) begin
        step(1);
        if (rxClkPulse === 1'b1) begin
          if (n > 0) chk({rxCarrier, rxData}, {1'b1, ~p});
          else chk({rxCarrier, 1'b0}, 2'h2);
          p = rxData;
          n++;
        end
      end
    join
    chk({1'b0, n >= 24 - MEA_LOCK_BITS}, 2'h1);
    step(2);
    chk({rxCarrier, 1'b0}, 2'h0);
  endtask : t_rx
  // Collision in mid frame, then heartbeat, then twisted pair mode
  task t_col;
    mediumSelect = MEA_PHY_THICK;
    txEn = 1'b1;
    for (int i = 0; i < 8; i++) push(1'b1);
    txValid = 1'b0;
    i_xcvr.colBurst(5);
    chk({colDetect, txAbort}, 2'h3);
    chk({auiTxPos | auiTxNeg, colLedOeN}, 2'h0);
    txEn = 1'b0;
    step(30);
    chk({txAbort, colLedOeN}, 2'h1);
    i_xcvr.colBurst(5);
    chk({colDetect, colLedOeN}, 2'h3);
    mediumSelect = MEA_PHY_TP_STD;
    step(2);
    i_xcvr.colBurst(5);
    chk({colDetect, txAbort}, 2'h0);
  endtask : t_col
  task tally_and_finish;
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    step(5);
    rst = 1'b0;
    step(2);
    t_clk();
    t_medium();
    t_tx();
    t_fill();
    t_rx();
    t_col();
    tally_and_finish();
  end
  // Watchdog well beyond the expected run of some 220 cycles
  initial begin
    #800000;
    bad_count++;
    tally_and_finish();
  end
endmodule : tb_top
bind mea_endec mea_checker i_chk (.clk(clk), .rst(rst), .txClk(txClk),
  .mediumSelect(mediumSelect), .thickThin(thickThin), .txEn(txEn), .txAbort(txAbort),
  .auiTxPos(auiTxPos), .auiTxNeg(auiTxNeg), .auiRxSquelch(auiRxSquelch),
  .rxClkPulse(rxClkPulse), .rxCarrier(rxCarrier), .collisionPairIn(collisionPairIn),
  .colDetect(colDetect), .colLedOut(colLedOut), .colLedOeN(colLedOeN));
